// ===== core/sld_control.sv
// segment display controller top: bus registers, memory access and common scan
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module sld_control
    import sld_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  sleepMode,
    input  wire logic                  internalSlowOscillator,
    input  wire logic                  externalSlowCrystal,
    output logic      [COM_COUNT-1:0]  comDrive,
    output logic      [SEG_COUNT-1:0]  segDrive,
    output logic                       drivePolarity,
    output logic                       waveformTypeB,
    output logic                       biasQuarter,
    output logic      [1:0]            biasNetwork,
    output logic                       quickChargeActive,
    output logic      [3:0]            topBiasLevel,
    output logic      [2:0]            pumpClockDivider
);

    typedef struct packed {
        logic [7:0]           ctrl0;
        logic [7:0]           ctrl1;
        logic [7:0]           ctrl2;
        logic                 useCrystal;
        logic [7:0]           ptr1Sector;
        logic [7:0]           ptr1Low;
        logic [7:0]           ptr2Sector;
        logic [7:0]           ptr2Low;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
        sld_state_e           state;
        logic [2:0]           phase;
        logic [3:0]           chargeCount;
        logic                 quickCharge;
        sld_network_e         network;
        logic [COM_COUNT-1:0] com;
        logic [SEG_COUNT-1:0] seg;
        logic                 polarity;
    } sld_ctrl_s;

    sld_ctrl_s            s;
    sld_ctrl_s            next_s;
    sld_target_e          target;
    logic                 setupPhase;
    logic                 accessWrite;
    logic                 memHit;
    logic                 memWrite;
    logic [MEM_AW-1:0]    memAddr;
    logic [7:0]           memReadData;
    logic [SEG_COUNT-1:0] scanBits;
    logic                 running;
    logic                 subTick;
    logic                 displayTick;
    logic [2:0]           rsel;
    logic [2:0]           lastPhase;
    logic [7:0]           readByte;
    logic [7:0]           wbyte;

    function automatic sld_target_e decodeTarget(input logic [ADDR_W-1:0] a);
        sld_target_e t;
        t = TGT_NONE;
        if (a[ADDR_W-1:8] == DIRECT_PAGE && a[1:0] == 2'h0) begin
            t = TGT_DIRECT;
        end else begin
            unique case (a)
                OFF_CTRL0:       t = TGT_CTRL0;
                OFF_CTRL1:       t = TGT_CTRL1;
                OFF_CTRL2:       t = TGT_CTRL2;
                OFF_CLOCK_SEL:   t = TGT_CLOCK_SEL;
                OFF_PTR1_SECTOR: t = TGT_PTR1_SECTOR;
                OFF_PTR1_LOW:    t = TGT_PTR1_LOW;
                OFF_PTR2_SECTOR: t = TGT_PTR2_SECTOR;
                OFF_PTR2_LOW:    t = TGT_PTR2_LOW;
                OFF_IND1_DATA:   t = TGT_IND1;
                OFF_IND2_DATA:   t = TGT_IND2;
                OFF_STATUS:      t = TGT_STATUS;
                default:         t = TGT_NONE;
            endcase
        end
        return t;
    endfunction

    // sector selected and low address inside display memory
    function automatic logic indirectHit(input logic [7:0] sector, input logic [7:0] low);
        return (sector == DISPLAY_SECTOR) && (low[7:MEM_AW] == '0);
    endfunction

    // network held outside the quick-charge interval
    function automatic sld_network_e holdNetwork(input logic [2:0] code);
        sld_network_e n;
        n = NET_1170K;
        if (code[2]) begin
            n = NET_225K;
        end else begin
            unique case (code[1:0])
                RSEL_1170K[1:0]: n = NET_1170K;
                RSEL_225K[1:0]:  n = NET_225K;
                RSEL_60K[1:0]:   n = NET_60K;
                RSEL_QC_HI[1:0]: n = NET_1170K;
            endcase
        end
        return n;
    endfunction

    function automatic logic quickMode(input logic [2:0] code);
        return code[2] || (code == RSEL_QC_HI);
    endfunction

    sld_tick_gen uTick (
        .ref_clk                (ref_clk),
        .reset                  (reset),
        .run                    (running),
        .useCrystal             (s.useCrystal),
        .internalSlowOscillator (internalSlowOscillator),
        .externalSlowCrystal    (externalSlowCrystal),
        .subTick                (subTick),
        .displayTick            (displayTick)
    );

    sld_display_ram uRam (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .writeEnable (memWrite),
        .address     (memAddr),
        .writeData   (wbyte),
        .readData    (memReadData),
        .scanCommon  (s.phase),
        .scanBits    (scanBits)
    );

    always_comb begin
        next_s = s;
        target = decodeTarget(paddr);
        setupPhase = psel && !penable;
        accessWrite = psel && penable && pwrite && s.pready && pstrb[0];
        wbyte = pwdata[7:0];
        running = s.ctrl0[ENABLE_BIT] && !sleepMode;
        rsel = s.ctrl0[RSEL_LSB +: 3];
        memHit = 1'b0;
        memAddr = paddr[MEM_AW+1:2];
        unique case (target)
            TGT_IND1: begin
                memHit = indirectHit(s.ptr1Sector, s.ptr1Low);
                memAddr = s.ptr1Low[MEM_AW-1:0];
            end
            TGT_IND2: begin
                memHit = indirectHit(s.ptr2Sector, s.ptr2Low);
                memAddr = s.ptr2Low[MEM_AW-1:0];
            end
            TGT_DIRECT: begin
                memHit = 1'b1;
            end
            default: begin
                memHit = 1'b0;
            end
        endcase
        memWrite = accessWrite && memHit;

        unique case (s.ctrl2[DUTY_LSB +: 2])
            DUTY_SIXTH:  lastPhase = LAST_PHASE_6;
            DUTY_EIGHTH: lastPhase = LAST_PHASE_8;
            default:     lastPhase = LAST_PHASE_4;
        endcase

        // register read data, latched in the setup cycle
        unique case (target)
            TGT_CTRL0:       readByte = s.ctrl0;
            TGT_CTRL1:       readByte = s.ctrl1;
            TGT_CTRL2:       readByte = s.ctrl2;
            TGT_CLOCK_SEL:   readByte = {7'h00, s.useCrystal};
            TGT_PTR1_SECTOR: readByte = s.ptr1Sector;
            TGT_PTR1_LOW:    readByte = s.ptr1Low;
            TGT_PTR2_SECTOR: readByte = s.ptr2Sector;
            TGT_PTR2_LOW:    readByte = s.ptr2Low;
            TGT_IND1,
            TGT_IND2,
            TGT_DIRECT:      readByte = memHit ? memReadData : 8'h00;
            TGT_STATUS:      readByte = {s.state == DISP_SCAN, s.quickCharge,
                                         s.network, 1'b0, s.phase};
            default:         readByte = 8'h00;
        endcase
        next_s.pready = setupPhase;
        next_s.pslverr = setupPhase && (target == TGT_NONE);
        if (setupPhase) begin
            next_s.prdata = {24'h000000, readByte};
        end

        // register writes at the access edge
        if (accessWrite) begin
            unique case (target)
                TGT_CTRL0:       next_s.ctrl0 = wbyte;
                TGT_CTRL1:       next_s.ctrl1 = wbyte & CTRL1_MASK;
                TGT_CTRL2:       next_s.ctrl2 = wbyte & CTRL2_MASK;
                TGT_CLOCK_SEL:   next_s.useCrystal = wbyte[0];
                TGT_PTR1_SECTOR: next_s.ptr1Sector = wbyte;
                TGT_PTR1_LOW:    next_s.ptr1Low = wbyte;
                TGT_PTR2_SECTOR: next_s.ptr2Sector = wbyte;
                TGT_PTR2_LOW:    next_s.ptr2Low = wbyte;
                default: begin
                end
            endcase
        end

        // common scan and quick charge
        unique case (s.state)
            DISP_OFF: begin
                next_s.phase = '0;
                next_s.chargeCount = '0;
                next_s.quickCharge = 1'b0;
                next_s.network = holdNetwork(rsel);
                next_s.com = '0;
                next_s.seg = '0;
                next_s.polarity = 1'b0;
                if (running) begin
                    next_s.state = DISP_SCAN;
                    if (quickMode(rsel)) begin
                        next_s.chargeCount = {1'b0, s.ctrl1[QCT_LSB +: 3]} + 4'h1;
                        next_s.quickCharge = 1'b1;
                        next_s.network = NET_60K;
                    end
                end
            end
            DISP_SCAN: begin
                next_s.com = '0;
                next_s.com[s.phase] = 1'b1;
                next_s.seg = scanBits;
                if (!running) begin
                    next_s.state = DISP_OFF;
                    next_s.com = '0;
                    next_s.seg = '0;
                end else if (displayTick) begin
                    if (s.phase >= lastPhase) begin
                        next_s.phase = '0;
                        if (s.ctrl0[WAVE_BIT]) begin
                            next_s.polarity = !s.polarity;
                        end
                    end else begin
                        next_s.phase = s.phase + 3'h1;
                    end
                    if (!s.ctrl0[WAVE_BIT]) begin
                        next_s.polarity = !s.polarity;
                    end
                    if (quickMode(rsel)) begin
                        next_s.chargeCount = {1'b0, s.ctrl1[QCT_LSB +: 3]} + 4'h1;
                        next_s.quickCharge = 1'b1;
                        next_s.network = NET_60K;
                    end else begin
                        next_s.quickCharge = 1'b0;
                        next_s.network = holdNetwork(rsel);
                    end
                end else if (s.quickCharge && subTick) begin
                    next_s.chargeCount = s.chargeCount - 4'h1;
                    if (s.chargeCount == 4'h1) begin
                        next_s.quickCharge = 1'b0;
                        next_s.network = holdNetwork(rsel);
                    end
                end else if (!s.quickCharge) begin
                    next_s.network = holdNetwork(rsel);
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s <= '0;
            s.ctrl0 <= CTRL_RESET;
            s.ctrl1 <= CTRL_RESET;
            s.ctrl2 <= CTRL_RESET;
            s.state <= DISP_OFF;
            s.network <= NET_1170K;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign comDrive = s.com;
    assign segDrive = s.seg;
    assign drivePolarity = s.polarity;
    assign waveformTypeB = s.ctrl0[WAVE_BIT];
    assign biasQuarter = s.ctrl2[BIAS_BIT];
    assign biasNetwork = s.network;
    assign quickChargeActive = s.quickCharge;
    assign topBiasLevel = s.ctrl1[TOP_LSB +: 4];
    assign pumpClockDivider = s.ctrl2[PUMP_LSB +: 3];

endmodule

// ===== core/sld_display_ram.sv
// display memory with one bus port and a whole-common scan port
`timescale 1ns/10ps
module sld_display_ram
    import sld_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 writeEnable,
    input  wire logic [MEM_AW-1:0]    address,
    input  wire logic [7:0]           writeData,
    output logic      [7:0]           readData,
    input  wire logic [2:0]           scanCommon,
    output logic      [SEG_COUNT-1:0] scanBits
);

    typedef struct packed {
        logic [MEM_DEPTH-1:0][7:0] mem;
    } sld_ram_s;

    sld_ram_s s;
    sld_ram_s next_s;

    always_comb begin
        next_s = s;
        if (writeEnable) begin
            next_s.mem[address] = writeData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign readData = s.mem[address];

    // one byte per segment, one bit per common
    genvar g;
    generate
        for (g = 0; g < SEG_COUNT; g++) begin : gScan
            assign scanBits[g] = s.mem[g][scanCommon];
        end
    endgenerate

endmodule

// ===== core/sld_pkg.sv
// constants, types and register map of the segment display controller
package sld_pkg;

    localparam int SEG_COUNT = 46;
    localparam int COM_COUNT = 8;
    localparam int MEM_DEPTH = 64;
    localparam int MEM_AW    = 6;
    localparam int ADDR_W    = 12;

    // register byte addresses
    localparam logic [ADDR_W-1:0] OFF_CTRL0       = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_CTRL1       = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_CTRL2       = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_CLOCK_SEL   = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_PTR1_SECTOR = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_PTR1_LOW    = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_PTR2_SECTOR = 12'h018;
    localparam logic [ADDR_W-1:0] OFF_PTR2_LOW    = 12'h01C;
    localparam logic [ADDR_W-1:0] OFF_IND1_DATA   = 12'h020;
    localparam logic [ADDR_W-1:0] OFF_IND2_DATA   = 12'h024;
    localparam logic [ADDR_W-1:0] OFF_STATUS      = 12'h028;
    localparam logic [ADDR_W-1:0] OFF_DIRECT_BASE = 12'h100;
    localparam logic [3:0]        DIRECT_PAGE     = 4'h1;

    localparam logic [7:0] DISPLAY_SECTOR = 8'h04;

    // first control register fields
    localparam int WAVE_BIT      = 7;
    localparam int BIAS_KIND_BIT = 6;
    localparam int RSEL_LSB      = 1;
    localparam int ENABLE_BIT    = 0;
    // second control register fields
    localparam int QCT_LSB       = 5;
    localparam int TOP_LSB       = 0;
    localparam logic [7:0] CTRL1_MASK = 8'hEF;
    // third control register fields
    localparam int PUMP_LSB      = 5;
    localparam int DUTY_LSB      = 1;
    localparam int BIAS_BIT      = 0;
    localparam logic [7:0] CTRL2_MASK = 8'hE7;

    localparam logic [7:0] CTRL_RESET = 8'h00;

    // resistor network codes
    localparam logic [2:0] RSEL_1170K = 3'h0;
    localparam logic [2:0] RSEL_225K  = 3'h1;
    localparam logic [2:0] RSEL_60K   = 3'h2;
    localparam logic [2:0] RSEL_QC_HI = 3'h3;

    // duty codes and active commons
    localparam logic [1:0] DUTY_QUARTER = 2'h0;
    localparam logic [1:0] DUTY_SIXTH   = 2'h1;
    localparam logic [1:0] DUTY_EIGHTH  = 2'h2;
    localparam logic [2:0] LAST_PHASE_4 = 3'h3;
    localparam logic [2:0] LAST_PHASE_6 = 3'h5;
    localparam logic [2:0] LAST_PHASE_8 = 3'h7;

    // subsystem clock to display clock divider
    localparam int         SUB_DIVIDE    = 8;
    localparam logic [2:0] DIV_LAST      = 3'(SUB_DIVIDE - 1);

    typedef enum logic [1:0] {NET_1170K, NET_225K, NET_60K} sld_network_e;
    typedef enum logic [0:0] {DISP_OFF, DISP_SCAN} sld_state_e;
    typedef enum logic [3:0] {
        TGT_CTRL0, TGT_CTRL1, TGT_CTRL2, TGT_CLOCK_SEL, TGT_PTR1_SECTOR,
        TGT_PTR1_LOW, TGT_PTR2_SECTOR, TGT_PTR2_LOW, TGT_IND1, TGT_IND2,
        TGT_STATUS, TGT_DIRECT, TGT_NONE
    } sld_target_e;

endpackage

// ===== core/sld_tick_gen.sv
// subsystem clock selection, edge ticks and divide-by-eight display tick
`timescale 1ns/10ps
module sld_tick_gen
    import sld_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic run,
    input  wire logic useCrystal,
    input  wire logic internalSlowOscillator,
    input  wire logic externalSlowCrystal,
    output logic      subTick,
    output logic      displayTick
);

    typedef struct packed {
        logic       prevLevel;
        logic [2:0] divCount;
        logic       subTick;
        logic       displayTick;
    } sld_tick_s;

    sld_tick_s s;
    sld_tick_s next_s;
    logic      level;
    logic      rise;

    always_comb begin
        next_s = s;
        level = useCrystal ? externalSlowCrystal : internalSlowOscillator;
        rise = level && !s.prevLevel;
        next_s.prevLevel = level;
        next_s.subTick = rise;
        next_s.displayTick = 1'b0;
        if (!run) begin
            next_s.divCount = '0;
        end else if (rise) begin
            next_s.divCount = s.divCount + 3'h1;
            next_s.displayTick = (s.divCount == DIV_LAST);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign subTick = s.subTick;
    assign displayTick = s.displayTick;

endmodule

// ===== sim/sld_control_checker.sv
// port assertions for the segment display controller
`timescale 1ns/10ps
module sld_control_checker
    import sld_pkg::*;
(
    input wire logic                 ref_clk,
    input wire logic                 reset,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 sleepMode,
    input wire logic [COM_COUNT-1:0] comDrive,
    input wire logic [SEG_COUNT-1:0] segDrive,
    input wire logic [1:0]           biasNetwork,
    input wire logic                 quickChargeActive
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_sleep_blanks: assert property (sleepMode |=> comDrive == '0 && segDrive == '0)
        else $error("drive active in sleep");
    a_com_onehot: assert property ($onehot0(comDrive))
        else $error("more than one common");
    a_com_order: assert property (
        comDrive != '0 && $past(comDrive) != '0 && comDrive != $past(comDrive)
        |-> comDrive == ($past(comDrive) << 1) || comDrive == 8'h01)
        else $error("common out of order");
    a_phase_hold: assert property (
        $changed(comDrive) && comDrive != '0 |=> ($stable(comDrive) || comDrive == '0) [*8])
        else $error("common phase too short");
    a_seg_blank: assert property (comDrive == '0 |-> segDrive == '0)
        else $error("segments driven without common");
    a_quick_net: assert property (quickChargeActive |-> biasNetwork == 2'h2)
        else $error("quick charge not on low network");
    a_net_legal: assert property (biasNetwork != 2'h3)
        else $error("illegal network code");
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_err_ready: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside access");
    cover property (quickChargeActive ##1 !quickChargeActive);
    cover property (comDrive == 8'h20 ##[1:200] comDrive == 8'h01);
    cover property (pslverr);
endmodule
bind sld_control sld_control_checker chk_u (.ref_clk, .reset, .psel, .penable, .pready,
    .pslverr, .sleepMode, .comDrive, .segDrive, .biasNetwork, .quickChargeActive);

// ===== sim/sld_control_test.sv
// self-checking bench for the segment display controller
`timescale 1ns/10ps
module sld_control_test
    import sld_pkg::*;
    ;
    logic                                 ref_clk = 1'b0;
    logic                                 reset = 1'b1;
    logic [ADDR_W-1:0]                    paddr = '0;
    logic                                 psel = 1'b0;
    logic                                 penable = 1'b0;
    logic                                 pwrite = 1'b0;
    logic [31:0]                          pwdata = '0;
    logic [3:0]                           pstrb = 4'hF;
    logic                                 sleepMode = 1'b0;
    logic                                 internalSlowOscillator = 1'b0;
    logic                                 externalSlowCrystal = 1'b0;
    logic [31:0]                          prdata;
    logic                                 pready, pslverr, drivePolarity, waveformTypeB;
    logic                                 biasQuarter, quickChargeActive;
    logic [COM_COUNT-1:0]                 comDrive;
    logic [SEG_COUNT-1:0]                 segDrive;
    logic [1:0]                           biasNetwork;
    logic [3:0]                           topBiasLevel;
    logic [2:0]                           pumpClockDivider;
    logic [COM_COUNT-1:0][SEG_COUNT-1:0] image;
    logic [15:0]                          phaseLen;
    logic [2:0]                           rs [3] = '{3'h3, 3'h4, 3'h7};
    logic [2:0]                           qt [3] = '{3'h2, 3'h0, 3'h5};
    logic [1:0]                           nt [3] = '{2'h0, 2'h1, 2'h1};
    logic [8:0]                           r;
    int                                   fail_count = 0;
    int                                   check_count = 0;
    int                                   cycles = 0;
    int                                   n;

    sld_control dut_u (.ref_clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .sleepMode, .internalSlowOscillator, .externalSlowCrystal,
        .comDrive, .segDrive, .drivePolarity, .waveformTypeB, .biasQuarter, .biasNetwork,
        .quickChargeActive, .topBiasLevel, .pumpClockDivider);
    sld_panel_model panel_u (.ref_clk, .comDrive, .segDrive, .image, .phaseLen);

    always #4 ref_clk = ~ref_clk;
    always begin
        repeat (4) @(posedge ref_clk);
        internalSlowOscillator <= ~internalSlowOscillator;
    end
    always begin
        repeat (7) @(posedge ref_clk);
        externalSlowCrystal <= ~externalSlowCrystal;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [7:0] d,
                       output logic [8:0] res);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        res = {pslverr, prdata[7:0]};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [8:0] x;
        apb(a, 1'b1, d, x);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [8:0] exp);
        logic [8:0] x;
        apb(a, 1'b0, 8'h00, x);
        check(48'(x), 48'(exp));
    endtask
    function automatic logic [7:0] pat(input int k);
        return 8'(k * 37 + 5);
    endfunction
    function automatic logic [SEG_COUNT-1:0] row(input int c);
        logic [SEG_COUNT-1:0] v;
        logic [7:0]           p;
        for (int k = 0; k < SEG_COUNT; k++) begin
            p = pat(k);
            v[k] = (c < 6) ? p[c] : 1'b0;
        end
        return v;
    endfunction

    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        rd(OFF_CTRL0, 9'h000);
        rd(OFF_CTRL1, 9'h000);
        rd(OFF_CTRL2, 9'h000);
        apb(12'h040, 1'b0, 8'h00, r);
        check(48'(r[8]), 48'h1);
        wr(OFF_CTRL0, 8'h8E);
        wr(OFF_CTRL1, 8'hFF);
        wr(OFF_CTRL2, 8'hFF);
        rd(OFF_CTRL0, 9'h08E);
        rd(OFF_CTRL1, 9'h0EF);
        rd(OFF_CTRL2, 9'h0E7);
        check(48'({waveformTypeB, biasQuarter, topBiasLevel, pumpClockDivider}), 48'h1FF);
        pstrb <= 4'h0;
        wr(OFF_CTRL1, 8'h00);
        pstrb <= 4'hF;
        rd(OFF_CTRL1, 9'h0EF);
        wr(OFF_PTR1_SECTOR, DISPLAY_SECTOR);
        wr(OFF_PTR1_LOW, 8'h00);
        wr(OFF_IND1_DATA, 8'hA5);
        rd(OFF_DIRECT_BASE, 9'h0A5);
        rd(OFF_IND1_DATA, 9'h0A5);
        wr(OFF_DIRECT_BASE + 12'h0FC, 8'h3C);
        wr(OFF_PTR2_SECTOR, DISPLAY_SECTOR);
        wr(OFF_PTR2_LOW, 8'h3F);
        rd(OFF_IND2_DATA, 9'h03C);
        wr(OFF_PTR2_SECTOR, 8'h03);
        rd(OFF_IND2_DATA, 9'h000);
        for (int k = 0; k < SEG_COUNT; k++) begin
            wr(OFF_DIRECT_BASE + 12'(4 * k), pat(k));
        end
        wr(OFF_CTRL2, 8'h02);
        wr(OFF_CTRL0, 8'h05);
        repeat (900) @(posedge ref_clk);
        for (int c = 0; c < COM_COUNT; c++) begin
            check(48'(image[c]), 48'(row(c)));
        end
        check(48'(phaseLen), 48'd64);
        while (comDrive === 8'h02) @(posedge ref_clk);
        while (comDrive !== 8'h02) @(posedge ref_clk);
        r[0] = drivePolarity;
        while (comDrive !== 8'h04) @(posedge ref_clk);
        check(48'(drivePolarity ^ r[0]), 48'h1);
        for (int k = 0; k < 3; k++) begin
            wr(OFF_CTRL0, {5'h00, 2'(k), 1'b1});
            repeat (3) @(posedge ref_clk);
            check(48'(biasNetwork), 48'(k));
        end
        wr(OFF_DIRECT_BASE, ~pat(0));
        repeat (900) @(posedge ref_clk);
        check(48'(image[0][0]), 48'h0);
        wr(OFF_CLOCK_SEL, 8'h01);
        repeat (1500) @(posedge ref_clk);
        check(48'(phaseLen), 48'd112);
        wr(OFF_CLOCK_SEL, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(OFF_CTRL1, {qt[i], 5'h00});
            wr(OFF_CTRL0, {4'h0, rs[i], 1'b1});
            while (quickChargeActive === 1'b1) @(posedge ref_clk);
            while (quickChargeActive !== 1'b1) @(posedge ref_clk);
            check(48'(biasNetwork), 48'h2);
            n = 0;
            while (quickChargeActive === 1'b1) begin
                @(posedge ref_clk);
                n++;
            end
            check(48'(n > 8 * qt[i] && n <= 8 * qt[i] + 9), 48'h1);
            check(48'(biasNetwork), 48'(nt[i]));
        end
        sleepMode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(48'(comDrive), 48'h0);
        check(48'(segDrive), 48'h0);
        sleepMode <= 1'b0;
        repeat (100) @(posedge ref_clk);
        check(48'(comDrive != '0), 48'h1);
        wr(OFF_CTRL0, 8'h04);
        repeat (2) @(posedge ref_clk);
        check(48'(comDrive), 48'h0);
        check(48'(segDrive), 48'h0);
        rd(OFF_STATUS, 9'h020);
        print_verdict();
    end
endmodule

// ===== sim/sld_panel_model.sv
// panel model: latches segment rows per common and times phases
`timescale 1ns/10ps
module sld_panel_model
    import sld_pkg::*;
(
    input  wire logic                                 ref_clk,
    input  wire logic [COM_COUNT-1:0]                 comDrive,
    input  wire logic [SEG_COUNT-1:0]                 segDrive,
    output logic      [COM_COUNT-1:0][SEG_COUNT-1:0] image,
    output logic      [15:0]                          phaseLen
);
    logic [COM_COUNT-1:0] prevCom = '0;
    logic [15:0]          runLen = '0;
    initial image = '0;
    initial phaseLen = '0;
    always @(posedge ref_clk) begin
        prevCom <= comDrive;
        runLen <= (comDrive != prevCom) ? 16'h1 : runLen + 16'h1;
        if (comDrive != prevCom && comDrive != '0 && prevCom != '0) begin
            phaseLen <= runLen;
        end
        for (int c = 0; c < COM_COUNT; c++) begin
            if (comDrive[c]) begin
                image[c] <= segDrive;
            end
        end
    end
endmodule
